// ===== cogt_trim_bank.sv
// Offset and fine-gain trim register bank with per-input trim selection
`include "cogt_cfg.svh"
module cogt_trim_bank
    import cogt_pkg::*;
#(
    parameter int ADDR_W = `COGT_ADDR_W
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [15:0] REG_WDATA_I,
    output logic [15:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    output logic [3:0] FUSE_ADDR_O,
    input wire logic [15:0] FUSE_DATA_I,
    output logic FUSE_DONE_O,
    input wire logic CORE2_SEL_B_I,
    input wire logic CORE3_SEL_D_I,
    output logic [11:0] CORE2_OFS_O,
    output logic [11:0] CORE3_OFS_O,
    output logic [11:0] CORE4_OFS_O,
    output logic [11:0] CORE5_OFS_O,
    output logic [4:0] CORE0_GAIN_O,
    output logic [4:0] CORE1_GAIN_O,
    output logic [4:0] CORE2_GAIN_O
);
    import cogt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage: offsets 0..5 = 2A,2B,3C,3D,4,5; gains 0..3 = 0,1,2A,2B
    cogt_ofs_t ofs_r [`COGT_N_OFS];
    cogt_gain_t gain_r [`COGT_N_GAIN];
    logic load_we;
    logic [3:0] load_idx;
    logic fuse_done;

    if (ADDR_W < 12) begin : g_bad_addr_w
        $error("cogt_trim_bank: ADDR_W must hold 12-bit offsets");
    end

    // Map an address to an offset trim index, 7 when not an offset trim
    function automatic logic [2:0] ofs_index(input logic [ADDR_W-1:0] a);
        unique case (a[11:0])
            `COGT_OFFSET_TRIM_CORE2_INPUT_A_ADDR: ofs_index = 3'd0;
            `COGT_OFFSET_TRIM_CORE2_INPUT_B_ADDR: ofs_index = 3'd1;
            `COGT_OFFSET_TRIM_CORE3_INPUT_C_ADDR: ofs_index = 3'd2;
            `COGT_OFFSET_TRIM_CORE3_INPUT_D_ADDR: ofs_index = 3'd3;
            `COGT_OFFSET_TRIM_CORE4_ADDR: ofs_index = 3'd4;
            `COGT_OFFSET_TRIM_CORE5_ADDR: ofs_index = 3'd5;
            default: ofs_index = 3'd7;
        endcase
    endfunction

    // Map an address to a gain trim index, 7 when not a gain trim
    function automatic logic [2:0] gain_index(input logic [ADDR_W-1:0] a);
        unique case (a[11:0])
            `COGT_GAIN_TRIM_CORE0_ADDR: gain_index = 3'd0;
            `COGT_GAIN_TRIM_CORE1_ADDR: gain_index = 3'd1;
            `COGT_GAIN_TRIM_CORE2_INPUT_A_ADDR: gain_index = 3'd2;
            `COGT_GAIN_TRIM_CORE2_INPUT_B_ADDR: gain_index = 3'd3;
            default: gain_index = 3'd7;
        endcase
    endfunction

    cogt_fuse_loader #(
        .N_TRIM(`COGT_N_TRIM)
    ) u_loader (
        .CLK_I(CLK_I),
        .RSTN_I(RSTN_I),
        .fuse_addr_o(FUSE_ADDR_O),
        .load_we_o(load_we),
        .load_idx_o(load_idx),
        .done_o(fuse_done)
    );
    assign FUSE_DONE_O = fuse_done;

    ////////////////////////////////////////////////////////////////////////
    // Register writes; fuse loading owns the bank until done
    logic [2:0] wr_ofs;
    logic [2:0] wr_gain;
    assign wr_ofs = ofs_index(REG_ADDR_I);
    assign wr_gain = gain_index(REG_ADDR_I);

    // Reserved bits are stored as written, except gain bits 15:8, which are dropped and read zero; software keeps them zero
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < `COGT_N_OFS; i++) begin
                ofs_r[i] <= `COGT_OFS_RESET;
            end
        end else if (load_we && load_idx < 4'(`COGT_N_OFS)) begin
            ofs_r[load_idx[2:0]] <= FUSE_DATA_I;
        end else if (fuse_done && REG_WR_I && wr_ofs != 3'd7) begin
            ofs_r[wr_ofs] <= REG_WDATA_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < `COGT_N_GAIN; i++) begin
                gain_r[i] <= `COGT_GAIN_RESET;
            end
        end else if (load_we && load_idx >= 4'(`COGT_N_OFS)) begin
            gain_r[2'(load_idx - 4'(`COGT_N_OFS))] <= FUSE_DATA_I[7:0];
        end else if (fuse_done && REG_WR_I && wr_gain != 3'd7) begin
            gain_r[wr_gain[1:0]] <= REG_WDATA_I[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads: one cycle latency, unmapped reads return zero
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            REG_RDATA_O <= 16'h0000;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I;
            if (REG_RD_I) begin
                if (wr_ofs != 3'd7) begin
                    REG_RDATA_O <= ofs_r[wr_ofs];
                end else if (wr_gain != 3'd7) begin
                    REG_RDATA_O <= {8'h00, gain_r[wr_gain[1:0]]};
                end else begin
                    REG_RDATA_O <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trims applied to the cores, chosen by the input being sampled
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CORE2_OFS_O <= 12'h000;
            CORE3_OFS_O <= 12'h000;
            CORE4_OFS_O <= 12'h000;
            CORE5_OFS_O <= 12'h000;
        end else begin
            // Unsigned correction passes straight through, no sign extension
            CORE2_OFS_O <= CORE2_SEL_B_I ? ofs_r[1][`COGT_OFS_MSB:0]
                                         : ofs_r[0][`COGT_OFS_MSB:0];
            CORE3_OFS_O <= CORE3_SEL_D_I ? ofs_r[3][`COGT_OFS_MSB:0]
                                         : ofs_r[2][`COGT_OFS_MSB:0];
            CORE4_OFS_O <= ofs_r[4][`COGT_OFS_MSB:0];
            CORE5_OFS_O <= ofs_r[5][`COGT_OFS_MSB:0];
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CORE0_GAIN_O <= 5'h00;
            CORE1_GAIN_O <= 5'h00;
            CORE2_GAIN_O <= 5'h00;
        end else begin
            CORE0_GAIN_O <= gain_r[0][`COGT_GAIN_MSB:0];
            CORE1_GAIN_O <= gain_r[1][`COGT_GAIN_MSB:0];
            CORE2_GAIN_O <= CORE2_SEL_B_I ? gain_r[3][`COGT_GAIN_MSB:0]
                                          : gain_r[2][`COGT_GAIN_MSB:0];
        end
    end
endmodule

// ===== cogt_cfg.svh
// Offsets, field layouts, reset values and trim counts for the trim bank
`ifndef COGT_CFG_SVH
`define COGT_CFG_SVH
`define COGT_ADDR_W 12
`define COGT_OFFSET_TRIM_CORE2_INPUT_A_ADDR 12'h334
`define COGT_OFFSET_TRIM_CORE2_INPUT_B_ADDR 12'h336
`define COGT_OFFSET_TRIM_CORE3_INPUT_C_ADDR 12'h338
`define COGT_OFFSET_TRIM_CORE3_INPUT_D_ADDR 12'h33A
`define COGT_OFFSET_TRIM_CORE4_ADDR 12'h33C
`define COGT_OFFSET_TRIM_CORE5_ADDR 12'h33E
`define COGT_GAIN_TRIM_CORE0_ADDR 12'h360
`define COGT_GAIN_TRIM_CORE1_ADDR 12'h361
`define COGT_GAIN_TRIM_CORE2_INPUT_A_ADDR 12'h362
`define COGT_GAIN_TRIM_CORE2_INPUT_B_ADDR 12'h363
`define COGT_OFS_MSB 11
`define COGT_GAIN_MSB 4
`define COGT_OFS_RESET 16'h0000
`define COGT_GAIN_RESET 8'h00
`define COGT_N_OFS 6
`define COGT_N_GAIN 4
`define COGT_N_TRIM 10
`endif

// ===== cogt_pkg.sv
// Types shared by the trim bank
package cogt_pkg;
    typedef enum logic [1:0] {
        COGT_LOADING = 2'b00,
        COGT_RUN = 2'b01
    } cogt_state_t;
    typedef logic [15:0] cogt_ofs_t;
    typedef logic [7:0] cogt_gain_t;
endpackage

// ===== cogt_fuse_loader.sv
// Walks the fuse storage once after reset and hands each trim its default
`include "cogt_cfg.svh"
module cogt_fuse_loader
    import cogt_pkg::*;
#(
    parameter int N_TRIM = `COGT_N_TRIM
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    output logic [3:0] fuse_addr_o,
    output logic load_we_o,
    output logic [3:0] load_idx_o,
    output logic done_o
);
    cogt_state_t state_r;
    logic [3:0] idx_r;

    if (N_TRIM < 1 || N_TRIM > 16) begin : g_bad_n_trim
        $error("cogt_fuse_loader: N_TRIM out of range");
    end

    // The fuse word named by load_idx_o is copied at the edge after load_we_o rises
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= COGT_LOADING;
            idx_r <= 4'h0;
            load_we_o <= 1'b0;
            load_idx_o <= 4'h0;
        end else begin
            load_we_o <= 1'b0;
            unique case (state_r)
                COGT_LOADING: begin
                    load_we_o <= 1'b1;
                    load_idx_o <= idx_r;
                    if (idx_r == 4'(N_TRIM - 1)) begin
                        state_r <= COGT_RUN;
                    end else begin
                        idx_r <= idx_r + 4'h1;
                    end
                end
                COGT_RUN: begin
                end
                default: state_r <= COGT_RUN;
            endcase
        end
    end

    // Address follows the pending load, so the bank captures the word it names
    assign fuse_addr_o = load_idx_o;
    assign done_o = (state_r == COGT_RUN) && !load_we_o;
endmodule

// ===== cogt_trim_bank_chk.sv
// Port assertions for the trim bank
module cogt_trim_bank_chk (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic REG_RVALID_O,
    input wire logic FUSE_DONE_O,
    input wire logic CORE2_SEL_B_I,
    input wire logic CORE3_SEL_D_I,
    input wire logic [11:0] REG_ADDR_I,
    input wire logic [11:0] CORE2_OFS_O,
    input wire logic [11:0] CORE3_OFS_O,
    input wire logic [11:0] CORE4_OFS_O,
    input wire logic [11:0] CORE5_OFS_O,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic [4:0] CORE0_GAIN_O,
    input wire logic [4:0] CORE2_GAIN_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    logic [11:0] wa;
    // Address of an accepted write; zero is unmapped, so idle cycles match nothing
    assign wa = (REG_WR_I && FUSE_DONE_O) ? REG_ADDR_I : 12'h000;
    property p_rv; 1 |=> REG_RVALID_O == $past(REG_RD_I); endproperty
    a_rv: assert property (p_rv) else $error("read valid wrong");
    property p_o4; wa == 12'h33c |=> ##1 CORE4_OFS_O == $past(REG_WDATA_I[11:0], 2); endproperty
    a_o4: assert property (p_o4) else $error("core4 offset wrong");
    property p_o5; wa == 12'h33e |=> ##1 CORE5_OFS_O == $past(REG_WDATA_I[11:0], 2); endproperty
    a_o5: assert property (p_o5) else $error("core5 offset wrong");
    property p_g0; wa == 12'h360 |=> ##1 CORE0_GAIN_O == $past(REG_WDATA_I[4:0], 2); endproperty
    a_g0: assert property (p_g0) else $error("core0 gain wrong");
    property p_ob;
        wa == 12'h336 ##1 CORE2_SEL_B_I |=> CORE2_OFS_O == $past(REG_WDATA_I[11:0], 2);
    endproperty
    a_ob: assert property (p_ob) else $error("core2 input b offset wrong");
    property p_od;
        wa == 12'h33a ##1 CORE3_SEL_D_I |=> CORE3_OFS_O == $past(REG_WDATA_I[11:0], 2);
    endproperty
    a_od: assert property (p_od) else $error("core3 input d offset wrong");
    property p_ga;
        wa == 12'h362 ##1 !CORE2_SEL_B_I |=> CORE2_GAIN_O == $past(REG_WDATA_I[4:0], 2);
    endproperty
    a_ga: assert property (p_ga) else $error("core2 input a gain wrong");
    property p_dn; !FUSE_DONE_O |-> ##[0:12] FUSE_DONE_O; endproperty
    a_dn: assert property (p_dn) else $error("fuse load too slow");
    c_rd: cover property (REG_RVALID_O);
    c_ob: cover property (wa == 12'h336 ##1 CORE2_SEL_B_I);
    c_dn: cover property ($rose(FUSE_DONE_O));
endmodule
bind cogt_trim_bank cogt_trim_bank_chk u_chk (
    .CLK_I(CLK_I),
    .RSTN_I(RSTN_I),
    .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I),
    .REG_RVALID_O(REG_RVALID_O),
    .FUSE_DONE_O(FUSE_DONE_O),
    .CORE2_SEL_B_I(CORE2_SEL_B_I),
    .CORE3_SEL_D_I(CORE3_SEL_D_I),
    .REG_ADDR_I(REG_ADDR_I),
    .CORE2_OFS_O(CORE2_OFS_O),
    .CORE3_OFS_O(CORE3_OFS_O),
    .CORE4_OFS_O(CORE4_OFS_O),
    .CORE5_OFS_O(CORE5_OFS_O),
    .REG_WDATA_I(REG_WDATA_I),
    .CORE0_GAIN_O(CORE0_GAIN_O),
    .CORE2_GAIN_O(CORE2_GAIN_O)
);

// ===== test_converter_offset_gain_trim_bank.sv
// Self-checking bench for the trim bank
module test_converter_offset_gain_trim_bank;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK_I = 0, RSTN_I = 0, REG_WR_I = 0, REG_RD_I = 0, REG_RVALID_O, FUSE_DONE_O;
    logic CORE2_SEL_B_I = 0, CORE3_SEL_D_I = 0;
    logic [11:0] REG_ADDR_I = 0, CORE2_OFS_O, CORE3_OFS_O, CORE4_OFS_O, CORE5_OFS_O;
    logic [15:0] REG_WDATA_I = 0, REG_RDATA_O, FUSE_DATA_I, v, mdl [10], exp_q [$];
    logic [4:0] CORE0_GAIN_O, CORE1_GAIN_O, CORE2_GAIN_O;
    logic [3:0] FUSE_ADDR_O;
    logic [11:0] adr [10] = '{12'h334, 12'h336, 12'h338, 12'h33a, 12'h33c,
        12'h33e, 12'h360, 12'h361, 12'h362, 12'h363};
    int bad_count = 0, samples_checked = 0, cyc = 0, i, p;
    cogt_trim_bank uut (
        .CLK_I(CLK_I),
        .RSTN_I(RSTN_I),
        .REG_ADDR_I(REG_ADDR_I),
        .REG_WR_I(REG_WR_I),
        .REG_RD_I(REG_RD_I),
        .REG_WDATA_I(REG_WDATA_I),
        .REG_RDATA_O(REG_RDATA_O),
        .REG_RVALID_O(REG_RVALID_O),
        .FUSE_ADDR_O(FUSE_ADDR_O),
        .FUSE_DATA_I(FUSE_DATA_I),
        .FUSE_DONE_O(FUSE_DONE_O),
        .CORE2_SEL_B_I(CORE2_SEL_B_I),
        .CORE3_SEL_D_I(CORE3_SEL_D_I),
        .CORE2_OFS_O(CORE2_OFS_O),
        .CORE3_OFS_O(CORE3_OFS_O),
        .CORE4_OFS_O(CORE4_OFS_O),
        .CORE5_OFS_O(CORE5_OFS_O),
        .CORE0_GAIN_O(CORE0_GAIN_O),
        .CORE1_GAIN_O(CORE1_GAIN_O),
        .CORE2_GAIN_O(CORE2_GAIN_O)
    );
    // Fuse storage is read combinationally; the model doubles as its contents
    assign FUSE_DATA_I = mdl[FUSE_ADDR_O];
    always #25 CLK_I = ~CLK_I;
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic acc(logic w, logic r, logic [11:0] a, logic [15:0] d, logic [15:0] e);
        @(posedge CLK_I);
        REG_WR_I <= w;
        REG_RD_I <= r;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        if (r) exp_q.push_back(e);
    endtask
    task automatic cores(logic s);
        @(posedge CLK_I);
        CORE2_SEL_B_I <= s;
        CORE3_SEL_D_I <= s;
        repeat (3) @(posedge CLK_I);
        check("c2o", 16'(CORE2_OFS_O), mdl[s]);
        check("c3o", 16'(CORE3_OFS_O), mdl[2 + s]);
        check("c4o", 16'(CORE4_OFS_O), mdl[4]);
        check("c5o", 16'(CORE5_OFS_O), mdl[5]);
        check("c0g", 16'(CORE0_GAIN_O), mdl[6]);
        check("c1g", 16'(CORE1_GAIN_O), mdl[7]);
        check("c2g", 16'(CORE2_GAIN_O), mdl[8 + s]);
    endtask
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        if (REG_RVALID_O === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spurious read", 16'h0001, 16'h0000);
            end else begin
                check("read", REG_RDATA_O, exp_q.pop_front());
            end
        end
        if (cyc == 1000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        void'($urandom(78818));
        for (i = 0; i < 10; i++) begin
            mdl[i] = 16'($urandom()) & (i < 6 ? 16'h0fff : 16'h001f);
        end
        repeat (6) @(posedge CLK_I);
        check("done in reset", 16'(FUSE_DONE_O), 16'h0000);
        RSTN_I <= 1'b1;
        repeat (14) @(posedge CLK_I);
        check("done", 16'(FUSE_DONE_O), 16'h0001);
        check("fuse addr", 16'(FUSE_ADDR_O), 16'h0009);
        for (p = 0; p < 3; p++) begin
            for (i = 0; i < 10 && p > 0; i++) begin
                v = 16'($urandom()) & (i < 6 ? 16'h0fff : 16'h001f);
                // Index 4 also reads in the write cycle and must see the old value
                acc(1'b1, i == 4, adr[i], v, mdl[i]);
                mdl[i] = v;
            end
            for (i = 0; i < 10; i++) acc(1'b0, 1'b1, adr[i], 16'h0000, mdl[i]);
            acc(1'b1, 1'b0, 12'h3ff, 16'h0fff, 16'h0000);
            acc(1'b0, 1'b1, 12'h3ff, 16'h0000, 16'h0000);
            acc(1'b0, 1'b0, 12'h000, 16'h0000, 16'h0000);
            cores(!p[0]);
            cores(p[0]);
        end
        check("pending", 16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule
